// ---- logic/dcx_map.svh ----
`ifndef DCX_MAP_SVH
`define DCX_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DCX_OFF_HCS 8'h00
`define DCX_OFF_SEL 8'h04
`define DCX_OFF_XFER 8'h08
`define DCX_OFF_EMC 8'h0C
`define DCX_OFF_FSR 8'h10
// ****************************************************************
// Field positions
// ****************************************************************
`define DCX_HCS_DBGEN_BIT 0
`define DCX_HCS_HALT_BIT 1
`define DCX_HCS_HALTED_BIT 16
`define DCX_HCS_READY_BIT 17
`define DCX_SEL_DIR_BIT 16
`define DCX_EMC_WTE_BIT 24
`define DCX_EMC_HFC_BIT 10
`define DCX_EMC_RVC_BIT 0
`define DCX_FSR_HALTED_BIT 0
`define DCX_FSR_VCATCH_BIT 3
// ****************************************************************
// Reset values
// ****************************************************************
`define DCX_EMC_RESET 32'h00000000
// ****************************************************************
// Selector codes
// ****************************************************************
`define DCX_CODE_RESUME 5'h0F
`define DCX_CODE_LAST_SEQ 5'h12
`define DCX_CODE_CTRL 5'h14
`endif

// ---- logic/dcx_pkg.sv ----
package dcx_pkg;
  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } dcx_reg_wr_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [4:0] sel;
    logic [31:0] wdata;
  } dcx_core_req_t;

  typedef enum logic [1:0] {DCX_XF_IDLE, DCX_XF_BUSY, DCX_XF_LOCAL} dcx_xfer_state_t;

  // ****************************************************************
  // Module state
  // ****************************************************************
  typedef struct packed {
    logic pend;
    logic write;
    logic [7:0] addr;
    logic rdWait;
    logic [31:0] hrdata;
  } dcx_ahb_state_t;

  typedef struct packed {
    logic pending;
    logic catchHalt;
  } dcx_vc_state_t;

  typedef struct packed {
    dcx_xfer_state_t xfer;
    logic debugEnable;
    logic haltReq;
    logic regReady;
    logic xferDir;
    logic [4:0] selCode;
    logic [31:0] xferWord;
    logic watchTraceEnable;
    logic hardFaultCatch;
    logic resetVectorCatch;
    logic [31:0] resumeAddress;
    logic haltedSeen;
    logic faultHalted;
    logic faultVcatch;
    logic resumeStrobe;
    logic [31:0] resumePc;
    dcx_core_req_t core;
  } dcx_main_state_t;
endpackage

// ---- logic/dcx_ahb_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcx_ahb_slave
  import dcx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output dcx_pkg::dcx_reg_wr_t wr,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData
);
  import dcx_pkg::*;

  dcx_ahb_state_t s;
  dcx_ahb_state_t next_s;
  logic unusedBits;

  // ****************************************************************
  // Bus phases
  // ****************************************************************
  // Reads take one wait state so that a write in the previous data
  // phase is already committed when the read value is sampled.
  always_comb
  begin
    next_s = s;
    if (s.pend && !s.rdWait)
      next_s.pend = 1'b0;
    if (s.rdWait)
    begin
      next_s.hrdata = rdData;
      next_s.rdWait = 1'b0;
    end
    if (hsel && htrans[1] && hready)
    begin
      next_s.pend = 1'b1;
      next_s.write = hwrite;
      next_s.addr = haddr[7:0];
      next_s.rdWait = !hwrite;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign hreadyout = !s.rdWait;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign wr.en = s.pend && s.write;
  assign wr.addr = s.addr;
  assign wr.data = hwdata;
  assign rdAddr = s.addr;
  assign unusedBits = ^{haddr[31:8], hsize};
endmodule // dcx_ahb_slave
`default_nettype wire

// ---- logic/dcx_vector_catch.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcx_vector_catch
  import dcx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic debugEnable,
  input wire logic hardFaultCatch,
  input wire logic resetVectorCatch,
  input wire logic excEnter,
  input wire logic excIsHardFault,
  input wire logic localReset,
  input wire logic excEntryBusy,
  output logic catchHalt
);
  import dcx_pkg::*;

  dcx_vc_state_t s;
  dcx_vc_state_t next_s;
  logic match;

  // ****************************************************************
  // Catch detection
  // ****************************************************************
  always_comb
  begin
    match = debugEnable &&
      ((excEnter && excIsHardFault && hardFaultCatch) ||
      (localReset && resetVectorCatch));
    next_s = s;
    next_s.catchHalt = 1'b0;
    if (match)
      next_s.pending = 1'b1;
    // Late or derived entries keep the busy flag up; wait them out
    if (s.pending && !excEntryBusy && !match)
    begin
      next_s.pending = 1'b0;
      next_s.catchHalt = 1'b1;
    end
    if (!debugEnable)
      next_s.pending = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign catchHalt = s.catchHalt;
endmodule // dcx_vector_catch
`default_nettype wire

// ---- logic/dcx_core_xfer.sv ----
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dcx_map.svh"
module dcx_core_xfer
  import dcx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic coreHalted,
  input wire logic [31:0] haltPc,
  output dcx_pkg::dcx_core_req_t coreReq,
  input wire logic coreRegAck,
  input wire logic [31:0] coreRegRdata,
  input wire logic excEnter,
  input wire logic excIsHardFault,
  input wire logic excEntryBusy,
  input wire logic localReset,
  output logic debugHalt,
  output logic watchTraceEnable,
  output logic resumeStrobe,
  output logic [31:0] resumePc
);
  import dcx_pkg::*;

  dcx_main_state_t s;
  dcx_main_state_t next_s;
  dcx_reg_wr_t wr;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic catchHalt;
  logic selValid;
  logic [4:0] wrCode;
  logic haltNow;
  logic haltNext;
  logic haltEntry;

  // ****************************************************************
  // Bus slave and catch logic
  // ****************************************************************
  dcx_ahb_slave u_bus (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr(wr),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  dcx_vector_catch u_catch (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .debugEnable(s.debugEnable),
    .hardFaultCatch(s.hardFaultCatch),
    .resetVectorCatch(s.resetVectorCatch),
    .excEnter(excEnter),
    .excIsHardFault(excIsHardFault),
    .localReset(localReset),
    .excEntryBusy(excEntryBusy),
    .catchHalt(catchHalt)
  );

  // ****************************************************************
  // Selector decode
  // ****************************************************************
  assign wrCode = wr.data[4:0];
  // Codes above the stack pointers, except the control code, are
  // reserved; such a selector write is dropped whole
  assign selValid = (wrCode <= `DCX_CODE_LAST_SEQ) ||
    (wrCode == `DCX_CODE_CTRL);

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Halt entry is the rising edge of the core's halted level; the
  // edge flop resets low like the level, so reset makes no false edge
  assign haltEntry = coreHalted && !s.haltedSeen;

  always_comb
  begin
    next_s = s;
    next_s.resumeStrobe = 1'b0;
    next_s.haltedSeen = coreHalted;
    // Capture where the core stopped; bit 0 is always zero
    if (haltEntry)
    begin
      next_s.resumeAddress = {haltPc[31:1], 1'b0};
      next_s.faultHalted = 1'b1;
    end

    // Transfer engine
    unique case (s.xfer)
      DCX_XF_IDLE:
      begin
        // Waits for an accepted selector write
      end
      DCX_XF_BUSY:
      begin
        if (coreRegAck)
        begin
          next_s.core.req = 1'b0;
          if (!s.xferDir)
            next_s.xferWord = coreRegRdata;
          next_s.regReady = 1'b1;
          next_s.xfer = DCX_XF_IDLE;
        end
      end
      DCX_XF_LOCAL:
      begin
        // The resume address lives here, not in the core
        if (s.xferDir)
          next_s.resumeAddress = {s.xferWord[31:1], 1'b0};
        else
          next_s.xferWord = s.resumeAddress;
        next_s.regReady = 1'b1;
        next_s.xfer = DCX_XF_IDLE;
      end
    endcase

    // Register writes
    if (wr.en)
    begin
      case (wr.addr)
        `DCX_OFF_HCS:
        begin
          next_s.debugEnable = wr.data[`DCX_HCS_DBGEN_BIT];
          next_s.haltReq = wr.data[`DCX_HCS_HALT_BIT];
        end
        `DCX_OFF_SEL:
        begin
          // Only a halted core with no transfer in flight takes one
          if (coreHalted && s.xfer == DCX_XF_IDLE && selValid)
          begin
            next_s.selCode = wrCode;
            next_s.xferDir = wr.data[`DCX_SEL_DIR_BIT];
            next_s.regReady = 1'b0;
            if (wrCode == `DCX_CODE_RESUME)
              next_s.xfer = DCX_XF_LOCAL;
            else
            begin
              // Whole word passes, so all status bits reach the core
              next_s.core.req = 1'b1;
              next_s.core.write = wr.data[`DCX_SEL_DIR_BIT];
              next_s.core.sel = wrCode;
              next_s.core.wdata = s.xferWord;
              next_s.xfer = DCX_XF_BUSY;
            end
          end
        end
        `DCX_OFF_XFER:
        begin
          // Held steady only while a transfer owns the word; after
          // power-on ready is low, yet the first load must land
          if (s.xfer == DCX_XF_IDLE)
            next_s.xferWord = wr.data;
        end
        `DCX_OFF_EMC:
        begin
          next_s.watchTraceEnable = wr.data[`DCX_EMC_WTE_BIT];
          next_s.hardFaultCatch = wr.data[`DCX_EMC_HFC_BIT];
          next_s.resetVectorCatch = wr.data[`DCX_EMC_RVC_BIT];
        end
        `DCX_OFF_FSR:
        begin
          if (wr.data[`DCX_FSR_HALTED_BIT])
            next_s.faultHalted = 1'b0;
          if (wr.data[`DCX_FSR_VCATCH_BIT])
            next_s.faultVcatch = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // Hardware events win over software clears
    if (haltEntry)
      next_s.faultHalted = 1'b1;
    // A catch that meets debug being switched off is dropped
    if (catchHalt && next_s.debugEnable)
    begin
      next_s.haltReq = 1'b1;
      next_s.faultVcatch = 1'b1;
    end

    // Local reset beats a same-cycle write of the enable
    if (localReset)
      next_s.watchTraceEnable = 1'b0;

    // Leaving debug state restarts at the resume address
    if (haltNow && !(next_s.haltReq && next_s.debugEnable) && coreHalted)
    begin
      next_s.resumeStrobe = 1'b1;
      next_s.resumePc = next_s.resumeAddress;
    end
  end

  assign haltNow = s.haltReq && s.debugEnable;
  assign haltNext = haltNow;

  // ****************************************************************
  // State register
  // ****************************************************************
  // Power-on reset zeroes everything, control register included
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Reserved fields and unmapped offsets read as zero
  always_comb
  begin
    rdData = '0;
    case (rdAddr)
      `DCX_OFF_HCS:
      begin
        rdData[`DCX_HCS_DBGEN_BIT] = s.debugEnable;
        rdData[`DCX_HCS_HALT_BIT] = s.haltReq;
        rdData[`DCX_HCS_HALTED_BIT] = coreHalted;
        rdData[`DCX_HCS_READY_BIT] = s.regReady;
      end
      `DCX_OFF_SEL:
      begin
        rdData[4:0] = s.selCode;
        rdData[`DCX_SEL_DIR_BIT] = s.xferDir;
      end
      `DCX_OFF_XFER:
        // Last transfer or load; meaningless while ready is low
        rdData = s.xferWord;
      `DCX_OFF_EMC:
      begin
        rdData[`DCX_EMC_WTE_BIT] = s.watchTraceEnable;
        rdData[`DCX_EMC_HFC_BIT] = s.hardFaultCatch;
        rdData[`DCX_EMC_RVC_BIT] = s.resetVectorCatch;
      end
      `DCX_OFF_FSR:
      begin
        rdData[`DCX_FSR_HALTED_BIT] = s.faultHalted;
        rdData[`DCX_FSR_VCATCH_BIT] = s.faultVcatch;
      end
      default:
      begin
      end
    endcase
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign coreReq = s.core;
  // AND of the haltReq and debugEnable flops, with no flop of its own
  assign debugHalt = haltNext;
  // The trace unit must treat its own reads as undefined when low
  assign watchTraceEnable = s.watchTraceEnable;
  assign resumeStrobe = s.resumeStrobe;
  assign resumePc = s.resumePc;
endmodule // dcx_core_xfer
`default_nettype wire

// ---- sim/dcx_core_xfer_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dcx_map.svh"
module dcx_core_xfer_chk
  import dcx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic coreHalted,
  input wire dcx_pkg::dcx_core_req_t coreReq,
  input wire logic coreRegAck,
  input wire logic excEntryBusy,
  input wire logic localReset,
  input wire logic debugHalt,
  input wire logic watchTraceEnable,
  input wire logic resumeStrobe
);
  import dcx_pkg::*;
  logic tk;
  logic [2:0] ph;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  assign tk = hsel && htrans[1] && hready && hwrite;
  // Write data phases of selector, halt control and monitor control
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ph <= 3'h0;
    else if (hready)
      ph <= {tk && haddr[7:0] == `DCX_OFF_SEL,
             tk && haddr[7:0] == `DCX_OFF_HCS,
             tk && haddr[7:0] == `DCX_OFF_EMC};
  end
  AST_REQ_SRC: assert property ($rose(coreReq.req) |-> $past(ph[2]))
    else $error("core request without selector write");
  AST_REQ_HOLD: assert property (coreReq.req && !coreRegAck |=>
    coreReq.req && $stable(coreReq.sel))
    else $error("core request dropped before acknowledge");
  AST_REQ_DROP: assert property (coreReq.req && coreRegAck |=> !coreReq.req)
    else $error("core request kept after acknowledge");
  AST_REQ_HALTED: assert property ($rose(coreReq.req) |-> coreHalted)
    else $error("core request while running");
  AST_RD_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=>
    !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_LRST: assert property (localReset && !ph[0] |=> !watchTraceEnable)
    else $error("trace enable kept over local reset");
  AST_WTE: assert property (ph[0] && hready && !localReset |=>
    watchTraceEnable == $past(hwdata[24]))
    else $error("trace enable differs from written bit");
  AST_HALT_SRC: assert property ($rose(debugHalt) && !$past(ph[1]) |->
    !$past(excEntryBusy, 2))
    else $error("catch halt during exception entry");
  AST_RESUME: assert property ($fell(debugHalt) && coreHalted |->
    ##[0:2] resumeStrobe)
    else $error("no resume strobe");
  AST_PULSE: assert property (resumeStrobe |=> !resumeStrobe)
    else $error("resume strobe longer than one cycle");
endmodule // dcx_core_xfer_chk
bind dcx_core_xfer dcx_core_xfer_chk chk (.ref_clk(ref_clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .coreHalted(coreHalted), .coreReq(coreReq), .coreRegAck(coreRegAck),
  .excEntryBusy(excEntryBusy), .localReset(localReset),
  .debugHalt(debugHalt), .watchTraceEnable(watchTraceEnable),
  .resumeStrobe(resumeStrobe));
`default_nettype wire

// ---- sim/dcx_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcx_core_model
  import dcx_pkg::*;
#(
  parameter logic [31:0] HALT_PC = 32'h00001F00
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire dcx_pkg::dcx_core_req_t coreReq,
  input wire logic debugHalt,
  input wire logic [3:0] ackDelay,
  output logic coreHalted,
  output logic [31:0] haltPc,
  output logic coreRegAck,
  output logic [31:0] coreRegRdata
);
  import dcx_pkg::*;
  logic [31:0] regs [32];
  logic [31:0] rdReg;
  logic [3:0] cnt;
  assign haltPc = HALT_PC;
  // Read data is only good with the acknowledge; scrambled otherwise
  assign coreRegRdata = coreRegAck ? rdReg : ~rdReg;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      coreHalted <= 1'b0;
      coreRegAck <= 1'b0;
      cnt <= 4'h0;
      rdReg <= 32'h0;
    end
    else
    begin
      coreHalted <= debugHalt;
      coreRegAck <= 1'b0;
      if (coreReq.req && !coreRegAck)
      begin
        cnt <= cnt + 4'h1;
        if (cnt >= ackDelay)
        begin
          cnt <= 4'h0;
          coreRegAck <= 1'b1;
          rdReg <= regs[coreReq.sel];
          if (coreReq.write)
            regs[coreReq.sel] <= coreReq.wdata;
        end
      end
    end
  end
endmodule // dcx_core_model
`default_nettype wire

// ---- sim/dcx_core_xfer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dcx_map.svh"
module dcx_core_xfer_test;
  import dcx_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic excEnter = 1'b0;
  logic excIsHardFault = 1'b0;
  logic excEntryBusy = 1'b0;
  logic localReset = 1'b0;
  logic [3:0] ackDelay = 4'h0;
  logic hreadyout, hresp, coreHalted, coreRegAck, debugHalt;
  logic watchTraceEnable, resumeStrobe;
  logic [31:0] hrdata, haltPc, coreRegRdata, resumePc, q, d;
  dcx_core_req_t coreReq;
  int nErrors = 0;
  int checksDone = 0;
  wire logic [2:0] watch = {coreHalted, resumeStrobe, debugHalt};
  initial forever #20 ref_clk = ~ref_clk;
  dcx_core_xfer uut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .coreHalted(coreHalted),
    .haltPc(haltPc), .coreReq(coreReq), .coreRegAck(coreRegAck),
    .coreRegRdata(coreRegRdata), .excEnter(excEnter),
    .excIsHardFault(excIsHardFault), .excEntryBusy(excEntryBusy),
    .localReset(localReset), .debugHalt(debugHalt),
    .watchTraceEnable(watchTraceEnable), .resumeStrobe(resumeStrobe),
    .resumePc(resumePc));
  dcx_core_model core (.ref_clk(ref_clk), .rstn(rstn), .coreReq(coreReq),
    .debugHalt(debugHalt), .ackDelay(ackDelay), .coreHalted(coreHalted),
    .haltPc(haltPc), .coreRegAck(coreRegAck), .coreRegRdata(coreRegRdata));
  // ********
  // Bus and check tasks
  // ********
  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      nErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that runs out counts as a mismatch and stops the run
  task automatic guard(input logic ok);
    if (ok !== 1'b1)
    begin
      nErrors++;
      $display("unexpected at %0t: wait ran out, got %h expected %h",
        $time, ok, 1'b1);
      endSim();
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    guard(hreadyout === 1'b1);
  endtask
  task automatic ahb(input logic w, logic [7:0] a, logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic poll();
    int n;
    n = 0;
    do
    begin
      ahb(1'b0, `DCX_OFF_HCS, 32'h0);
      n++;
    end
    while (q[`DCX_HCS_READY_BIT] !== 1'b1 && n < 30);
    guard(q[`DCX_HCS_READY_BIT]);
  endtask
  task automatic wait_for(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (watch[k] !== 1'b1 && n < 40);
    guard(watch[k]);
  endtask
  task automatic xfer(input logic [4:0] c, logic w, logic [31:0] wd,
    logic [3:0] dl);
    ackDelay <= dl;
    if (w)
      ahb(1'b1, `DCX_OFF_XFER, wd);
    ahb(1'b1, `DCX_OFF_SEL, {15'h0, w, 11'h0, c});
  endtask
  task automatic pulse(input logic hf, logic lr);
    excEnter <= hf;
    excIsHardFault <= hf;
    localReset <= lr;
    @(posedge ref_clk);
    excEnter <= 1'b0;
    excIsHardFault <= 1'b0;
    localReset <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // ********
  // Main sequence
  // ********
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rdchk(`DCX_OFF_EMC, `DCX_EMC_RESET);
    rdchk(`DCX_OFF_HCS, 32'h0);
    chk({31'h0, watchTraceEnable}, 32'h0);
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    rdchk(8'h20, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b1, `DCX_OFF_EMC, 32'hFFFFFFFF);
    rdchk(`DCX_OFF_EMC, 32'h01000401);
    chk({31'h0, watchTraceEnable}, 32'h1);
    pulse(1'b1, 1'b1);
    rdchk(`DCX_OFF_EMC, 32'h00000401);
    chk({31'h0, debugHalt}, 32'h0);
    rdchk(`DCX_OFF_FSR, 32'h0);
    $display("test control register finished");
    ahb(1'b1, `DCX_OFF_HCS, 32'h3);
    wait_for(2);
    rdchk(`DCX_OFF_HCS, 32'h00010003);
    // First load after power-on, with ready still low, must land
    xfer(5'h01, 1'b1, 32'hC0DE1234, 4'h0);
    poll();
    chk(core.regs[1], 32'hC0DE1234);
    xfer(`DCX_CODE_RESUME, 1'b0, 32'h0, 4'h0);
    poll();
    rdchk(`DCX_OFF_XFER, 32'h00001F00);
    for (int i = 0; i < 21; i++)
    begin
      if (i == 15 || i == 19)
        continue;
      d = {i[4:0], 11'h5A5, 16'hF00D};
      xfer(i[4:0], 1'b1, d, i[0] ? 4'h8 : 4'h0);
      if (i[0])
        rdchk(`DCX_OFF_HCS, 32'h00010003);
      poll();
      chk(core.regs[i], d);
      ahb(1'b1, `DCX_OFF_XFER, 32'h0);
      xfer(i[4:0], 1'b0, 32'h0, i[0] ? 4'h0 : 4'h5);
      poll();
      rdchk(`DCX_OFF_XFER, d);
    end
    ahb(1'b1, `DCX_OFF_SEL, 32'h00000013);
    rdchk(`DCX_OFF_HCS, 32'h00030003);
    rdchk(`DCX_OFF_SEL, 32'h00000014);
    $display("test register transfer finished");
    xfer(`DCX_CODE_RESUME, 1'b1, 32'h00002001, 4'h0);
    poll();
    xfer(`DCX_CODE_RESUME, 1'b0, 32'h0, 4'h0);
    poll();
    rdchk(`DCX_OFF_XFER, 32'h00002000);
    ahb(1'b1, `DCX_OFF_HCS, 32'h1);
    wait_for(1);
    chk(resumePc, 32'h00002000);
    $display("test resume finished");
    ahb(1'b1, `DCX_OFF_FSR, 32'h9);
    ahb(1'b1, `DCX_OFF_EMC, 32'h00000400);
    excEntryBusy <= 1'b1;
    pulse(1'b1, 1'b0);
    chk({31'h0, debugHalt}, 32'h0);
    excEntryBusy <= 1'b0;
    wait_for(0);
    ahb(1'b0, `DCX_OFF_FSR, 32'h0);
    chk(q & 32'h8, 32'h8);
    wait_for(2);
    ahb(1'b1, `DCX_OFF_HCS, 32'h1);
    wait_for(1);
    ahb(1'b1, `DCX_OFF_EMC, 32'h1);
    pulse(1'b1, 1'b0);
    chk({31'h0, debugHalt}, 32'h0);
    pulse(1'b0, 1'b1);
    chk({31'h0, debugHalt}, 32'h1);
    rdchk(`DCX_OFF_EMC, 32'h1);
    $display("test vector catch finished");
    endSim();
  end
endmodule // dcx_core_xfer_test
`default_nettype wire
